// [hw/ledsd_controller.sv]
// ledsd_controller: display controller end, driven by software over apb.
// assumes apb master on clk_sys; the led driver answers on the link pins.
`timescale 1ns/1ps
`default_nettype none
module ledsd_controller
  import ledsd_pkg::*;
#(
  parameter int HOLDOFF_DELAY_CYC = HOLDOFF_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ledsd_link_if.ctrl link
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LAT_LOW, ST_LAT_HIGH} ledsd_cstate_t;

  typedef struct packed {
    ledsd_cstate_t state;
    logic portCorr;
    logic latSel;
    logic blankN;
    logic pwmEn;
    logic [GS_BITS-1:0] txBuf;
    logic [GS_BITS-1:0] work;
    logic [GS_BITS-1:0] rxBuf;
    logic [8:0] bitsLeft;
    logic [4:0] div;
    logic sck;
    logic [TIMER_W-1:0] holdoff;
    logic [2:0] pwmDiv;
    logic pwmClk;
    logic gsIn;
    logic gsClk;
    logic lat;
    logic blankOut;
    logic corrIn;
    logic corrClk;
    logic sout1;
    logic sout2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ledsd_ctl_state_t;

  ledsd_ctl_state_t stateReg;
  ledsd_ctl_state_t stateNext;

  always_comb
  begin
    logic [31:0] rd;
    logic hit;
    logic [3:0] idx;
    logic wr;
    rd = '0;
    hit = 1'b1;
    idx = paddr[5:2];
    wr = psel && penable && stateReg.pready && pwrite && !stateReg.pslverr;
    stateNext = stateReg;
    stateNext.sout1 = link.grayscale_serial_out;
    stateNext.sout2 = stateReg.sout1;
    stateNext.pready = 1'b0;
    stateNext.pslverr = 1'b0;

    if (paddr == REG_CTRL)
      rd = 32'({stateReg.pwmEn, stateReg.blankN, 1'b0, stateReg.latSel, 1'b0});
    else if (paddr == REG_STATUS)
      rd = 32'({stateReg.holdoff != '0, stateReg.state != ST_IDLE});
    else if ((paddr & PAGE_MASK) == REG_TX_BASE && 32'(idx) < WORDS)
      rd = stateReg.txBuf[32'(idx) * 32 +: 32];
    else if ((paddr & PAGE_MASK) == REG_RX_BASE && 32'(idx) < WORDS)
      rd = stateReg.rxBuf[32'(idx) * 32 +: 32];
    else
      hit = 1'b0;

    // one wait state, then answer; unmapped gives pslverr
    if (psel && penable && !stateReg.pready)
    begin
      stateNext.pready = 1'b1;
      stateNext.prdata = pwrite ? '0 : rd;
      stateNext.pslverr = !hit;
    end

    if (stateReg.holdoff != '0)
      stateNext.holdoff = stateReg.holdoff - TIMER_W'(1);

    if (wr && paddr == REG_CTRL)
    begin
      stateNext.latSel = pwdata[CTRL_LAT_SEL];
      stateNext.blankN = pwdata[CTRL_BLANK_N];
      stateNext.pwmEn = pwdata[CTRL_PWM_EN];
      // commands while busy are dropped; a latching go is also dropped during the holdoff,
      // since its select level gives a strobe edge at once
      if (stateReg.state == ST_IDLE && (pwdata[CTRL_GO_GS] || pwdata[CTRL_GO_CORR])
          && !(pwdata[CTRL_GO_GS] && pwdata[CTRL_LAT_SEL] && stateReg.holdoff != '0))
      begin
        stateNext.state = ST_SHIFT;
        stateNext.portCorr = !pwdata[CTRL_GO_GS];
        stateNext.bitsLeft = pwdata[CTRL_GO_GS] ? 9'(GS_BITS) : 9'(CORR_BITS);
        stateNext.work = pwdata[CTRL_GO_GS] ? stateReg.txBuf
                         : {stateReg.txBuf[CORR_BITS-1:0], {PAD_BITS{1'b0}}};
        stateNext.div = 5'(SCK_HALF_CYC - 1);
        stateNext.lat = pwdata[CTRL_GO_GS] && pwdata[CTRL_LAT_SEL];
      end
    end
    else if (wr && (paddr & PAGE_MASK) == REG_TX_BASE)
    begin
      stateNext.txBuf[32'(idx) * 32 +: 32] = pwdata;
    end

    unique case (stateReg.state)
      ST_IDLE:
      begin
        stateNext.sck = 1'b0;
      end
      ST_SHIFT:
      begin
        if (stateReg.div != '0)
          stateNext.div = stateReg.div - 5'(1);
        else
        begin
          stateNext.div = 5'(SCK_HALF_CYC - 1);
          if (!stateReg.sck)
          begin
            stateNext.sck = 1'b1;
            stateNext.bitsLeft = stateReg.bitsLeft - 9'(1);
            if (!stateReg.portCorr)
              stateNext.rxBuf = {stateReg.rxBuf[GS_BITS-2:0], stateReg.sout2};
          end
          else
          begin
            stateNext.sck = 1'b0;
            stateNext.work = {stateReg.work[GS_BITS-2:0], 1'b0};
            if (stateReg.bitsLeft == '0)
            begin
              stateNext.state = stateReg.portCorr ? ST_IDLE : ST_LAT_LOW;
              if (stateReg.portCorr)
                stateNext.holdoff = TIMER_W'(HOLDOFF_DELAY_CYC);
            end
          end
        end
      end
      ST_LAT_LOW:
      begin
        stateNext.lat = 1'b0;
        if (stateReg.div != '0)
          stateNext.div = stateReg.div - 5'(1);
        else if (stateReg.holdoff == '0)
        begin
          stateNext.state = ST_LAT_HIGH;
          stateNext.div = 5'(SCK_HALF_CYC - 1);
          stateNext.lat = 1'b1;
        end
      end
      ST_LAT_HIGH:
      begin
        stateNext.lat = 1'b1;
        if (stateReg.div != '0)
          stateNext.div = stateReg.div - 5'(1);
        else
        begin
          stateNext.state = ST_IDLE;
          stateNext.lat = 1'b0;
        end
      end
    endcase

    if (stateReg.pwmEn)
    begin
      stateNext.pwmDiv = stateReg.pwmDiv + 3'(1);
      if (stateReg.pwmDiv == 3'(PWM_HALF_CYC - 1))
      begin
        stateNext.pwmDiv = '0;
        stateNext.pwmClk = !stateReg.pwmClk;
      end
    end
    else
    begin
      stateNext.pwmDiv = '0;
      stateNext.pwmClk = 1'b0;
    end

    stateNext.gsClk = stateNext.sck && !stateNext.portCorr;
    stateNext.corrClk = stateNext.sck && stateNext.portCorr;
    stateNext.gsIn = !stateNext.portCorr && stateNext.work[GS_BITS-1];
    stateNext.corrIn = stateNext.portCorr && stateNext.work[GS_BITS-1];
    // latch only while blanked, so no output glitches mid-period
    stateNext.blankOut = stateNext.blankN && !stateNext.lat
      && stateNext.state != ST_LAT_LOW && stateNext.state != ST_LAT_HIGH;
  end

  // reset holds blanking low until software sets CTRL_BLANK_N
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stateReg <= '0;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign prdata = stateReg.prdata;
  assign pready = stateReg.pready;
  assign pslverr = stateReg.pslverr;
  assign link.grayscale_serial_in = stateReg.gsIn;
  assign link.grayscale_serial_clock = stateReg.gsClk;
  assign link.grayscale_latch_strobe = stateReg.lat;
  assign link.blanking_n = stateReg.blankOut;
  assign link.correction_serial_in = stateReg.corrIn;
  assign link.correction_serial_clock = stateReg.corrClk;
  assign link.red_pwm_clock = stateReg.pwmClk;
  assign link.green_pwm_clock = stateReg.pwmClk;
  assign link.blue_pwm_clock = stateReg.pwmClk;

endmodule
`default_nettype wire

// [hw/ledsd_pkg.sv]
// ledsd_pkg: constants shared by the led driver link ends.
// assumes a 200 MHz clk_sys in both ends.
package ledsd_pkg;
  localparam int GS_BITS = 288;
  localparam int CORR_BITS = 216;
  localparam int CORR_SPLIT = 199;
  localparam int PAD_BITS = GS_BITS - CORR_BITS;
  localparam int GS_W = 12;
  localparam int CHANNELS = 8;
  localparam int COLORS = 3;
  localparam int CNT_W = 13;
  // function bits inside the correction latch
  localparam int FC_LO = 192;
  localparam int FC_W = 7;
  localparam int FC_AUTO_REPEAT = 195;
  localparam int FC_MODE_LO = 196;
  localparam int FC_TIMING_RESET = 198;
  localparam logic [1:0] MODE_10 = 2'h1;
  localparam logic [1:0] MODE_8 = 2'h2;
  localparam logic [CNT_W-1:0] PERIOD_12 = 13'h1000;
  localparam logic [CNT_W-1:0] PERIOD_10 = 13'h0400;
  localparam logic [CNT_W-1:0] PERIOD_8 = 13'h0100;
  localparam logic [GS_W-1:0] MASK_12 = 12'hFFF;
  localparam logic [GS_W-1:0] MASK_10 = 12'h3FF;
  localparam logic [GS_W-1:0] MASK_8 = 12'h0FF;
  // sampled pin positions in the device
  localparam int PIN_GSIN = 0;
  localparam int PIN_GSCK = 1;
  localparam int PIN_LAT = 2;
  localparam int PIN_BLANK = 3;
  localparam int PIN_CORRECTION_SERIAL_IN = 4;
  localparam int PIN_CORRECTION_SERIAL_CLOCK = 5;
  localparam int PIN_PWM0 = 6;
  localparam int PINS = 9;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  localparam int STROBE_MIN_MS = 3;
  localparam int STROBE_MAX_MS = 7;
  localparam int STROBE_CYC = (STROBE_MIN_MS + STROBE_MAX_MS) / 2 * NS_PER_MS / CLK_PERIOD_NS;
  localparam int HOLDOFF_MS = 7;
  localparam int HOLDOFF_CYC = HOLDOFF_MS * NS_PER_MS / CLK_PERIOD_NS + 1;
  localparam int TIMER_W = 21;
  localparam int SCK_HALF_CYC = 16;
  localparam int PWM_HALF_CYC = 4;
  // controller apb map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TX_BASE = 8'h40;
  localparam logic [7:0] REG_RX_BASE = 8'h80;
  localparam logic [7:0] PAGE_MASK = 8'hC3;
  localparam int WORDS = 9;
  localparam int CTRL_GO_GS = 0;
  localparam int CTRL_LAT_SEL = 1;
  localparam int CTRL_GO_CORR = 2;
  localparam int CTRL_BLANK_N = 3;
  localparam int CTRL_PWM_EN = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_HOLDOFF = 1;
endpackage

// [hw/ledsd_link_if.sv]
// ledsd_link_if: pins between the display controller and the led driver.
// assumes the bench instantiates it once and binds both modports.
`timescale 1ns/1ps
`default_nettype none
interface ledsd_link_if;
  logic grayscale_serial_in;
  logic grayscale_serial_clock;
  logic grayscale_serial_out;
  logic grayscale_latch_strobe;
  logic blanking_n;
  logic correction_serial_in;
  logic correction_serial_clock;
  logic correction_serial_out;
  logic red_pwm_clock;
  logic green_pwm_clock;
  logic blue_pwm_clock;
  logic [7:0] red_channel_output;
  logic [7:0] green_channel_output;
  logic [7:0] blue_channel_output;
  modport device (
    input grayscale_serial_in, grayscale_serial_clock, grayscale_latch_strobe, blanking_n,
    input correction_serial_in, correction_serial_clock,
    input red_pwm_clock, green_pwm_clock, blue_pwm_clock,
    output grayscale_serial_out, correction_serial_out,
    output red_channel_output, green_channel_output, blue_channel_output
  );
  modport ctrl (
    output grayscale_serial_in, grayscale_serial_clock, grayscale_latch_strobe, blanking_n,
    output correction_serial_in, correction_serial_clock,
    output red_pwm_clock, green_pwm_clock, blue_pwm_clock,
    input grayscale_serial_out, correction_serial_out,
    input red_channel_output, green_channel_output, blue_channel_output
  );
endinterface
`default_nettype wire

// [hw/ledsd_device.sv]
// ledsd_device: shift registers, latches and pwm counters of the led driver.
// assumes every link pin is asynchronous to clk_sys and toggles slower than clk_sys/4.
//
// Overview of operation
// - grayscale clock shifts 288-bit common register
// - latch low sample copies all to grayscale
// - latch high sample routes bits below 199 to correction latch, bits 199 up to the correction shift register
// - controller waits over 7 ms before latching
// - grayscale latch updates at once
// - controller latches only while blanked
// - blanking low forces all outputs off
// - controller blanks outputs from reset until software sets CTRL_BLANK_N
// - controller sets unused outputs to zero
// - on-time equals grayscale value clocks
// - twelve bits per output, red green blue
// - timing reset blanks on latch edge
// - auto repeat blanks at 4096th clock in 12-bit mode
// - correction clock shifts 216-bit register
// - correction latch readable through grayscale port
// - correction latch loads after idle delay
// - blanking clears and holds group counters
// - output on while counter within value
// - repeat period follows counter mode
`timescale 1ns/1ps
`default_nettype none
module ledsd_device
  import ledsd_pkg::*;
#(
  parameter int STROBE_DELAY_CYC = STROBE_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  ledsd_link_if.device link,
  output logic [FC_W-1:0] functionBits
);

  typedef struct packed {
    logic [PINS-1:0] s1;
    logic [PINS-1:0] s2;
    logic [PINS-1:0] s3;
    logic [GS_BITS-1:0] common;
    logic [GS_BITS-1:0] gsLatch;
    logic [CORR_BITS-1:0] corrShift;
    logic [CORR_BITS-1:0] corrLatch;
    logic latSample;
    logic [TIMER_W-1:0] strobeCnt;
    logic [COLORS-1:0][CNT_W-1:0] cnt;
    logic [COLORS-1:0][CHANNELS-1:0] chanOut;
    logic gsOut;
    logic corrOut;
  } ledsd_dev_state_t;

  ledsd_dev_state_t stateReg;
  ledsd_dev_state_t stateNext;
  logic [PINS-1:0] pins;

  assign pins = {link.blue_pwm_clock, link.green_pwm_clock, link.red_pwm_clock,
                 link.correction_serial_clock, link.correction_serial_in,
                 link.blanking_n, link.grayscale_latch_strobe,
                 link.grayscale_serial_clock, link.grayscale_serial_in};

  always_comb
  begin
    logic [PINS-1:0] rise;
    logic intBlank;
    logic autoRep;
    logic [CNT_W-1:0] period;
    logic [GS_W-1:0] gsMask;
    logic [GS_W-1:0] gsVal;
    rise = stateReg.s2 & ~stateReg.s3;
    intBlank = 1'b0;
    autoRep = stateReg.corrLatch[FC_AUTO_REPEAT];
    period = PERIOD_12;
    gsMask = MASK_12;
    gsVal = '0;
    stateNext = stateReg;
    // only s2 and s3 are read: s1 may be metastable
    stateNext.s1 = pins;
    stateNext.s2 = stateReg.s1;
    stateNext.s3 = stateReg.s2;

    if (rise[PIN_GSCK])
    begin
      stateNext.common = {stateReg.common[GS_BITS-2:0], stateReg.s2[PIN_GSIN]};
      stateNext.latSample = stateReg.s2[PIN_LAT];
    end

    if (rise[PIN_CORRECTION_SERIAL_CLOCK])
    begin
      stateNext.corrShift = {stateReg.corrShift[CORR_BITS-2:0], stateReg.s2[PIN_CORRECTION_SERIAL_IN]};
      stateNext.strobeCnt = TIMER_W'(STROBE_DELAY_CYC);
    end
    else if (stateReg.strobeCnt != '0)
    begin
      stateNext.strobeCnt = stateReg.strobeCnt - TIMER_W'(1);
      if (stateReg.strobeCnt == TIMER_W'(1))
      begin
        stateNext.corrLatch = stateReg.corrShift;
      end
    end

    // with a high select sample, a latch edge's writes override a serial edge's in the same cycle
    if (rise[PIN_LAT])
    begin
      intBlank = stateReg.corrLatch[FC_TIMING_RESET];
      if (!stateReg.latSample)
      begin
        stateNext.gsLatch = stateReg.common;
      end
      else
      begin
        stateNext.corrLatch[CORR_SPLIT-1:0] = stateReg.common[CORR_SPLIT-1:0];
        stateNext.corrShift[CORR_BITS-1:CORR_SPLIT] =
          stateReg.common[CORR_BITS-1:CORR_SPLIT];
        // old latch contents go to the top so they leave first
        stateNext.common = {stateReg.corrLatch, {PAD_BITS{1'b0}}};
      end
    end

    unique case (stateReg.corrLatch[FC_MODE_LO +: 2])
      MODE_10:
      begin
        period = PERIOD_10;
        gsMask = MASK_10;
      end
      MODE_8:
      begin
        period = PERIOD_8;
        gsMask = MASK_8;
      end
      default:
      begin
        period = PERIOD_12;
        gsMask = MASK_12;
      end
    endcase

    for (int g = 0; g < COLORS; g++)
    begin
      if (!stateReg.s2[PIN_BLANK] || intBlank)
      begin
        stateNext.cnt[g] = '0;
      end
      else if (rise[PIN_PWM0 + g])
      begin
        if (autoRep && stateReg.cnt[g] == period - CNT_W'(1))
        begin
          stateNext.cnt[g] = '0;
        end
        else if (stateReg.cnt[g] != period)
        begin
          // without repeat the counter parks past every value
          stateNext.cnt[g] = stateReg.cnt[g] + CNT_W'(1);
        end
      end
    end

    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      for (int c = 0; c < COLORS; c++)
      begin
        gsVal = stateReg.gsLatch[(ch * COLORS + c) * GS_W +: GS_W] & gsMask;
        stateNext.chanOut[c][ch] = stateReg.s2[PIN_BLANK]
          && stateReg.cnt[c] != '0
          && stateReg.cnt[c] <= {1'b0, gsVal};
      end
    end

    stateNext.gsOut = stateNext.common[GS_BITS-1];
    stateNext.corrOut = stateNext.corrShift[CORR_BITS-1];
  end

  // no reset on the real part; here reset gives a known start
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stateReg <= '0;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign link.grayscale_serial_out = stateReg.gsOut;
  assign link.correction_serial_out = stateReg.corrOut;
  assign link.red_channel_output = stateReg.chanOut[0];
  assign link.green_channel_output = stateReg.chanOut[1];
  assign link.blue_channel_output = stateReg.chanOut[2];
  assign functionBits = stateReg.corrLatch[FC_LO +: FC_W];

endmodule
`default_nettype wire

// [verif/ledsd_props.sv]
// ledsd_props: link-level checks between controller and device ends.
// assumes one clk_sys domain; link pins arrive as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module ledsd_props
#(
  parameter int HOLD = 300
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic grayscale_serial_in,
  input wire logic grayscale_serial_clock,
  input wire logic grayscale_serial_out,
  input wire logic grayscale_latch_strobe,
  input wire logic blanking_n,
  input wire logic correction_serial_in,
  input wire logic correction_serial_clock,
  input wire logic correction_serial_out,
  input wire logic [7:0] red_channel_output,
  input wire logic [7:0] green_channel_output,
  input wire logic [7:0] blue_channel_output
);
  logic sckQ;
  logic latQ;
  logic dckQ;
  logic [6:0] sckHist;
  logic [6:0] latHist;
  logic [6:0] dckHist;
  logic [4:0] sckHi;
  logic [4:0] latHi;
  logic [31:0] sinceCorr;
  // pin edges reach the device outputs a few cycles late, so keep a short history
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sckQ <= 1'b0;
      latQ <= 1'b0;
      dckQ <= 1'b0;
      sckHist <= 7'h00;
      latHist <= 7'h00;
      dckHist <= 7'h00;
      sckHi <= 5'h00;
      latHi <= 5'h00;
      sinceCorr <= 32'(HOLD);
    end
    else
    begin
      sckQ <= grayscale_serial_clock;
      latQ <= grayscale_latch_strobe;
      dckQ <= correction_serial_clock;
      sckHist <= {sckHist[5:0], grayscale_serial_clock & ~sckQ};
      latHist <= {latHist[5:0], grayscale_latch_strobe & ~latQ};
      dckHist <= {dckHist[5:0], correction_serial_clock & ~dckQ};
      sckHi <= grayscale_serial_clock ? sckHi + 5'h01 : 5'h00;
      // a select level held through a shift saturates
      latHi <= !grayscale_latch_strobe ? 5'h00 : (latHi == 5'h1F ? latHi : latHi + 5'h01);
      if (correction_serial_clock & ~dckQ)
        sinceCorr <= 32'h0;
      else if (sinceCorr < 32'(HOLD))
        sinceCorr <= sinceCorr + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_BLANK_FORCES_OFF: assert property ((!blanking_n)[*8] |->
    (red_channel_output | green_channel_output | blue_channel_output) == 8'h00)
    else $error("outputs on while blanked");
  AST_GS_OUT_AFTER_EDGE: assert property ($changed(grayscale_serial_out) |->
    (sckHist != 7'h00 || latHist != 7'h00)) else $error("serial out moved without clock");
  AST_CORR_OUT_AFTER_EDGE: assert property ($changed(correction_serial_out) |->
    (dckHist != 7'h00 || latHist != 7'h00)) else $error("corr out moved without clock");
  AST_GS_DATA_ON_LOW: assert property ($changed(grayscale_serial_in) |->
    !grayscale_serial_clock) else $error("serial data moved with clock high");
  AST_CORR_DATA_ON_LOW: assert property ($changed(correction_serial_in) |->
    !correction_serial_clock) else $error("corr data moved with clock high");
  AST_SCK_HIGH_TIME: assert property ($fell(grayscale_serial_clock) |->
    sckHi == 5'h10) else $error("serial clock high time wrong");
  AST_LAT_PULSE_WIDTH: assert property ($fell(grayscale_latch_strobe) |->
    (latHi == 5'h10 || latHi == 5'h1F)) else $error("latch pulse width wrong");
  AST_LAT_BLANKED: assert property (grayscale_latch_strobe |-> !blanking_n)
    else $error("latch while displaying");
  AST_LAT_AFTER_HOLDOFF: assert property ($rose(grayscale_latch_strobe) |->
    sinceCorr >= 32'(HOLD)) else $error("latch too soon after corr clock");
  AST_LAT_SCK_IDLE: assert property ($rose(grayscale_latch_strobe) |->
    !grayscale_serial_clock ##1 !grayscale_serial_clock) else $error("latch during shift");
  cover property ($rose(grayscale_latch_strobe));
  cover property ($fell(correction_serial_clock));
  cover property (red_channel_output[0] && blue_channel_output[7]);
endmodule
`default_nettype wire

// [verif/tb.sv]
// tb: apb-driven controller facing the device across the link interface.
// assumes the short delay parameters below; expectations derive from them.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ledsd_pkg::*;
  localparam int STROBE = 200;
  localparam int HOLD = 300;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [FC_W-1:0] functionBits;
  logic [31:0] rd;
  logic err;
  logic [287:0] corrBuf;
  logic [287:0] cfgBuf;
  logic [287:0] gsBuf;
  logic [287:0] rx;
  int bad_count = 0;
  int tests_run = 0;
  int r;
  int g;
  int b;
  ledsd_link_if link();
  ledsd_controller #(.HOLDOFF_DELAY_CYC(HOLD)) ledsd_controller_i (.clk_sys(clk_sys),
    .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  ledsd_device #(.STROBE_DELAY_CYC(STROBE)) ledsd_device_i (.clk_sys(clk_sys), .rst(rst),
    .link(link), .functionBits(functionBits));
  ledsd_props #(.HOLD(HOLD)) ledsd_props_i (.clk_sys(clk_sys), .rst(rst),
    .grayscale_serial_in(link.grayscale_serial_in),
    .grayscale_serial_clock(link.grayscale_serial_clock),
    .grayscale_serial_out(link.grayscale_serial_out),
    .grayscale_latch_strobe(link.grayscale_latch_strobe), .blanking_n(link.blanking_n),
    .correction_serial_in(link.correction_serial_in),
    .correction_serial_clock(link.correction_serial_clock),
    .correction_serial_out(link.correction_serial_out),
    .red_channel_output(link.red_channel_output),
    .green_channel_output(link.green_channel_output),
    .blue_channel_output(link.blue_channel_output));
  always #2.5 clk_sys = ~clk_sys;
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [287:0] exp, input logic [287:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      end_of_test();
    end
  endtask
  // polls status; a go write is refused while busy, so wait out every job
  task automatic job(input logic [31:0] ctrl);
    int n;
    n = 0;
    // a latching go is refused until the correction holdoff has run out
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while ((rd[STAT_BUSY] !== 1'b0 || rd[STAT_HOLDOFF] !== 1'b0) && n < 5000);
    apb(1'b1, REG_CTRL, ctrl);
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (rd[STAT_BUSY] !== 1'b0 && n < 5000);
    if (n >= 5000)
    begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic loadTx(input logic [287:0] v);
    for (int i = 0; i < WORDS; i++)
      apb(1'b1, REG_TX_BASE + 8'(4 * i), v[32*i +: 32]);
  endtask
  task automatic readRx();
    for (int i = 0; i < WORDS; i++)
    begin
      apb(1'b0, REG_RX_BASE + 8'(4 * i), 32'h0);
      rx[32*i +: 32] = rd;
    end
  endtask
  // on-time rounded to pwm periods of 8 sys cycles; sync slop is under half a period
  task automatic measure(input int n);
    r = 0;
    g = 0;
    b = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      r += int'(link.red_channel_output[0] === 1'b1);
      g += int'(link.green_channel_output[0] === 1'b1);
      b += int'(link.blue_channel_output[7] === 1'b1);
    end
    r = (r + 4) / 8;
    g = (g + 4) / 8;
    b = (b + 4) / 8;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", 288'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 288'h1, err);
    apb(1'b1, 8'h41, 32'hFFFFFFFF);
    chk("misaligned err", 288'h1, err);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status idle", 288'h0, rd);
    $display("test reset and map done");
    for (int i = 0; i < WORDS; i++)
      corrBuf[32*i +: 32] = 32'h9E3779B9 ^ (32'h01010101 * i);
    loadTx(corrBuf);
    job(32'h04);
    chk("fc before strobe", 288'h0, functionBits);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("holdoff", 288'h1, rd[STAT_HOLDOFF]);
    repeat (STROBE + 20) @(posedge clk_sys);
    chk("fc after strobe", corrBuf[198:192], functionBits);
    $display("test correction port done");
    cfgBuf = '0;
    cfgBuf[198:192] = 7'h07;
    cfgBuf[215:199] = 17'h1ABCD;
    loadTx(cfgBuf);
    job(32'h03);
    chk("fc from common", 288'h07, functionBits);
    gsBuf = '0;
    gsBuf[11:0] = 12'h003;
    gsBuf[287:276] = 12'h005;
    loadTx(gsBuf);
    job(32'h01);
    readRx();
    chk("latch readback", {corrBuf[215:0], 72'h0}, rx);
    job(32'h01);
    readRx();
    chk("common shift", gsBuf, rx);
    $display("test latch routing done");
    apb(1'b1, REG_CTRL, 32'h18);
    measure(600);
    chk("red0 periods", 288'h3, 288'(r));
    chk("green0 periods", 288'h0, 288'(g));
    chk("blue7 periods", 288'h5, 288'(b));
    apb(1'b1, REG_CTRL, 32'h10);
    // relight red, then blank while it is still on
    apb(1'b1, REG_CTRL, 32'h18);
    repeat (12) @(posedge clk_sys);
    apb(1'b1, REG_CTRL, 32'h10);
    repeat (10) @(posedge clk_sys);
    chk("blanked outputs", 288'h0, {link.red_channel_output, link.green_channel_output,
      link.blue_channel_output});
    apb(1'b1, REG_CTRL, 32'h18);
    measure(600);
    chk("red0 after reblank", 288'h3, 288'(r));
    $display("test pwm done");
    cfgBuf[198:192] = 7'h28;
    loadTx(cfgBuf);
    job(32'h03);
    chk("fc repeat mode8", 288'h28, functionBits);
    gsBuf[11:0] = 12'h103;
    loadTx(gsBuf);
    job(32'h01);
    apb(1'b1, REG_CTRL, 32'h18);
    // two whole 256-clock periods of 2048 sys cycles
    measure(4096);
    chk("red0 masked repeat", 288'h6, 288'(r));
    chk("blue7 repeat", 288'hA, 288'(b));
    $display("test auto repeat done");
    end_of_test();
  end
endmodule
`default_nettype wire
